// ### otam_alert_regs.sv
`timescale 1ns/10ps
`include "otam_defines.svh"

module otam_alert_regs (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire otam_pkg::otam_req_s req_i,
  input wire logic [`OTAM_TEMP_W-1:0] local_temp_i,
  input wire logic [`OTAM_TEMP_W-1:0] remote_one_temp_i,
  input wire logic [`OTAM_TEMP_W-1:0] remote_two_temp_i,
  input wire logic [`OTAM_TEMP_W-1:0] remote_three_temp_i,
  input wire logic [`OTAM_TEMP_W-1:0] remote_four_temp_i,
  input wire logic [`OTAM_TEMP_W-1:0] remote_one_secondary_limit_i,
  input wire logic [`OTAM_TEMP_W-1:0] remote_two_secondary_limit_i,
  input wire logic [`OTAM_TEMP_W-1:0] remote_three_limit_i,
  input wire logic [`OTAM_TEMP_W-1:0] remote_four_limit_i,
  input wire logic [`OTAM_HYST_W-1:0] hysteresis_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic [`OTAM_MASK_W-1:0] status_o,
  output logic second_overtemp_alert_n_o,
  output logic third_overtemp_alert_n_o
);

  otam_pkg::otam_state_s state;
  otam_pkg::otam_state_s next_state;

  // per-channel words, bit order {remote4, remote3, remote2, remote1, local}
  logic [`OTAM_MASK_W-1:0] chan_status;
  logic [`OTAM_MASK_W*`OTAM_TEMP_W-1:0] readings;
  logic [`OTAM_MASK_W*`OTAM_TEMP_W-1:0] limits;
  logic [`OTAM_TEMP_W-1:0] local_limit_word;

  // mask registers seen as plain bit vectors, and the events each pin lets through
  logic [`OTAM_MASK_W-1:0] second_mask_bits;
  logic [`OTAM_MASK_W-1:0] third_mask_bits;
  logic [`OTAM_MASK_W-1:0] second_events;
  logic [`OTAM_MASK_W-1:0] third_events;

  // register selection
  logic write_second;
  logic write_third;
  logic write_limit;
  logic [7:0] read_word;
  logic [`OTAM_MASK_W-1:0] wdata_mask;
  logic [`OTAM_LIMIT_W-1:0] wdata_limit;

  assign second_mask_bits = state.second_alert_mask;
  assign third_mask_bits = state.third_alert_mask;

  // the local limit is only seven bits wide; bit 7 is zero into the comparator
  assign local_limit_word = {1'b0, state.local_critical_limit};

  assign readings = {
    remote_four_temp_i,
    remote_three_temp_i,
    remote_two_temp_i,
    remote_one_temp_i,
    local_temp_i
  };

  assign limits = {
    remote_four_limit_i,
    remote_three_limit_i,
    remote_two_secondary_limit_i,
    remote_one_secondary_limit_i,
    local_limit_word
  };

  // reserved bits of a written byte are dropped here and read back as zero
  assign wdata_mask = req_i.wdata[`OTAM_MASK_W-1:0];
  assign wdata_limit = req_i.wdata[`OTAM_LIMIT_W-1:0];

  genvar ch;
  generate
    for (ch = 0; ch < `OTAM_MASK_W; ch++) begin : g_chan
      logic [`OTAM_TEMP_W-1:0] reading;
      logic [`OTAM_TEMP_W-1:0] limit;

      assign reading = readings[ch*`OTAM_TEMP_W +: `OTAM_TEMP_W];
      assign limit = limits[ch*`OTAM_TEMP_W +: `OTAM_TEMP_W];

      otam_channel_status u_status (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .reading_i(reading),
        .limit_i(limit),
        .hyst_i(hysteresis_i),
        .status_o(chan_status[ch])
      );

      // a set mask bit keeps this channel out of the pin's OR
      assign second_events[ch] =
        chan_status[ch] & ~second_mask_bits[ch];
      assign third_events[ch] =
        chan_status[ch] & ~third_mask_bits[ch];
    end
  endgenerate

  // command-byte decode; an unmapped byte selects nothing and reads zero
  always_comb begin
    write_second = 1'b0;
    write_third = 1'b0;
    write_limit = 1'b0;
    read_word = 8'h00;
    if (req_i.addr == `OTAM_ADDR_SECOND_MASK) begin
      write_second = req_i.wr;
      read_word = {3'h0, second_mask_bits};
    end else if (req_i.addr == `OTAM_ADDR_THIRD_MASK) begin
      write_third = req_i.wr;
      read_word = {3'h0, third_mask_bits};
    end else if (req_i.addr == `OTAM_ADDR_LOCAL_LIMIT) begin
      write_limit = req_i.wr;
      read_word = local_limit_word;
    end
  end

  always_comb begin
    next_state = state;
    next_state.rvalid = 1'b0;
    next_state.status = chan_status;
    if (write_second) begin
      next_state.second_alert_mask = wdata_mask;
    end
    if (write_third) begin
      next_state.third_alert_mask = wdata_mask;
    end
    if (write_limit) begin
      next_state.local_critical_limit = wdata_limit;
    end
    // a read in the same cycle as a write returns the old value
    if (req_i.rd) begin
      next_state.rvalid = 1'b1;
      next_state.rdata = read_word;
    end
    next_state.second_overtemp_alert_n = ~|second_events;
    next_state.third_overtemp_alert_n = ~|third_events;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state.second_alert_mask <= `OTAM_RST_SECOND_MASK;
      state.third_alert_mask <= `OTAM_RST_THIRD_MASK;
      state.local_critical_limit <= `OTAM_RST_LOCAL_LIMIT;
      state.rdata <= `OTAM_RST_RDATA;
      state.rvalid <= 1'b0;
      state.second_overtemp_alert_n <= `OTAM_ALERT_IDLE;
      state.third_overtemp_alert_n <= `OTAM_ALERT_IDLE;
      state.status <= `OTAM_RST_STATUS;
    end else begin
      state <= next_state;
    end
  end

  assign rdata_o = state.rdata;
  assign rvalid_o = state.rvalid;
  assign status_o = state.status;
  assign second_overtemp_alert_n_o = state.second_overtemp_alert_n;
  assign third_overtemp_alert_n_o = state.third_overtemp_alert_n;

endmodule : otam_alert_regs

// ### otam_defines.svh
`ifndef OTAM_DEFINES_SVH
`define OTAM_DEFINES_SVH

// command-byte offsets
`define OTAM_ADDR_SECOND_MASK 8'h0D
`define OTAM_ADDR_THIRD_MASK 8'h0E
`define OTAM_ADDR_LOCAL_LIMIT 8'h40

// power-on values
`define OTAM_RST_SECOND_MASK 5'h00
`define OTAM_RST_THIRD_MASK 5'h07
`define OTAM_RST_LOCAL_LIMIT 7'h55
`define OTAM_RST_RDATA 8'h00
`define OTAM_RST_STATUS 5'h00
`define OTAM_ALERT_IDLE 1'b1

// field layout
`define OTAM_MASK_W 5
`define OTAM_LIMIT_W 7
`define OTAM_TEMP_W 8
`define OTAM_HYST_W 5

// channel positions inside a mask or status word
`define OTAM_CH_LOCAL 0
`define OTAM_CH_REMOTE_ONE 1
`define OTAM_CH_REMOTE_TWO 2
`define OTAM_CH_REMOTE_THREE 3
`define OTAM_CH_REMOTE_FOUR 4

`endif

// ### otam_pkg.sv
`include "otam_defines.svh"

package otam_pkg;

  typedef logic [`OTAM_MASK_W-1:0] otam_mask_t;

  // one-bit-per-channel blocking word
  typedef struct packed {
    logic remote_four_block;
    logic remote_three_block;
    logic remote_two_secondary_block;
    logic remote_one_secondary_block;
    logic local_channel_block;
  } otam_mask_s;

  // register write/read request from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } otam_req_s;

  typedef struct packed {
    otam_mask_s second_alert_mask;
    otam_mask_s third_alert_mask;
    logic [`OTAM_LIMIT_W-1:0] local_critical_limit;
    logic [7:0] rdata;
    logic rvalid;
    logic second_overtemp_alert_n;
    logic third_overtemp_alert_n;
    logic [`OTAM_MASK_W-1:0] status;
  } otam_state_s;

endpackage : otam_pkg

// ### otam_channel_status.sv
`timescale 1ns/10ps
`include "otam_defines.svh"

// one channel's limit status with hysteresis: sets at reading >= limit,
// clears only when reading < limit - hysteresis
module otam_channel_status (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [`OTAM_TEMP_W-1:0] reading_i,
  input wire logic [`OTAM_TEMP_W-1:0] limit_i,
  input wire logic [`OTAM_HYST_W-1:0] hyst_i,
  output logic status_o
);

  logic [`OTAM_TEMP_W:0] clear_level;
  logic next_status;

  always_comb begin
    // a limit below the hysteresis borrows into the top bit of clear_level, so status never clears there
    clear_level = {1'b0, limit_i} - {4'h0, hyst_i};
    next_status = status_o;
    if (reading_i >= limit_i) begin
      next_status = 1'b1;
    end else if (!clear_level[`OTAM_TEMP_W] &&
                 ({1'b0, reading_i} < clear_level)) begin
      next_status = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      status_o <= 1'b0;
    end else begin
      status_o <= next_status;
    end
  end

endmodule : otam_channel_status

// ### otam_host_model.sv
`timescale 1ns/10ps
module otam_host_model (
  input wire logic clock_i,
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i,
  output otam_pkg::otam_req_s req_o
);
  initial req_o = '0;
  // one-cycle request pulse, then bounded poll for the read answer
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(negedge clock_i);
    req_o = {w, !w, a, d};
    @(negedge clock_i);
    req_o = '0;
    q = 8'hXX;
    for (int n = 0; n < 3 && !w; n++) begin
      if (rvalid_i === 1'b1) begin
        q = rdata_i;
        break;
      end
      @(negedge clock_i);
    end
  endtask : access
endmodule : otam_host_model

// ### otam_alert_regs_checker.sv
`timescale 1ns/10ps
module otam_alert_regs_checker (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire otam_pkg::otam_req_s req_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic [4:0] status_o,
  input wire logic second_overtemp_alert_n_o,
  input wire logic third_overtemp_alert_n_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  a_read_answer: assert property (req_i.rd |=> rvalid_o)
    else $error("read not answered");
  a_answer_pulse: assert property (!req_i.rd |=> !rvalid_o)
    else $error("stray read answer");
  a_limit_top_zero: assert property (rvalid_o |-> !rdata_o[7])
    else $error("read bit 7 set");
  a_mask_reserved: assert property (rvalid_o && $past(req_i.addr) != 8'h40
    |-> rdata_o[7:5] == 3'h0)
    else $error("reserved bits set");
  a_rdata_holds: assert property (!rvalid_o |-> $stable(rdata_o))
    else $error("read data moved");
  a_quiet_idle: assert property (status_o == 5'h00
    |-> second_overtemp_alert_n_o && third_overtemp_alert_n_o)
    else $error("alert without status");
  a_second_cause: assert property (!second_overtemp_alert_n_o |-> status_o != 5'h00)
    else $error("second alert uncaused");
  a_third_cause: assert property (!third_overtemp_alert_n_o |-> status_o != 5'h00)
    else $error("third alert uncaused");
  // mask copies kept from the request stream, reset to the power-on masks
  logic [4:0] shadow_second;
  logic [4:0] shadow_third;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      shadow_second <= 5'h00;
      shadow_third <= 5'h07;
    end else begin
      if (req_i.wr && req_i.addr == 8'h0D) begin
        shadow_second <= req_i.wdata[4:0];
      end
      if (req_i.wr && req_i.addr == 8'h0E) begin
        shadow_third <= req_i.wdata[4:0];
      end
    end
  end
  a_second_gating: assert property (second_overtemp_alert_n_o ==
    ~|(status_o & ~$past(shadow_second)))
    else $error("second alert gating wrong");
  a_third_gating: assert property (third_overtemp_alert_n_o ==
    ~|(status_o & ~$past(shadow_third)))
    else $error("third alert gating wrong");
endmodule : otam_alert_regs_checker
bind otam_alert_regs otam_alert_regs_checker chk (.clock_i(clock_i), .srst_i(srst_i),
  .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .status_o(status_o),
  .second_overtemp_alert_n_o(second_overtemp_alert_n_o),
  .third_overtemp_alert_n_o(third_overtemp_alert_n_o));

// ### otam_alert_regs_tb.sv
`timescale 1ns/10ps
module otam_alert_regs_tb;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] t [5] = '{default: 8'h00};
  logic [4:0] hy = 5'h05;
  logic [7:0] rdata_o;
  logic [7:0] q;
  logic rvalid_o;
  logic [4:0] status_o;
  logic a2;
  logic a3;
  otam_pkg::otam_req_s req;
  int failures = 0;
  int total_checks = 0;
  always #10 clock_i = ~clock_i;
  otam_host_model host (.clock_i(clock_i), .rvalid_i(rvalid_o), .rdata_i(rdata_o), .req_o(req));
  otam_alert_regs dut (.clock_i(clock_i), .srst_i(srst_i), .req_i(req), .local_temp_i(t[0]),
    .remote_one_temp_i(t[1]), .remote_two_temp_i(t[2]), .remote_three_temp_i(t[3]),
    .remote_four_temp_i(t[4]), .remote_one_secondary_limit_i(8'h30),
    .remote_two_secondary_limit_i(8'h30), .remote_three_limit_i(8'h30),
    .remote_four_limit_i(8'h30), .hysteresis_i(hy), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .status_o(status_o), .second_overtemp_alert_n_o(a2), .third_overtemp_alert_n_o(a3));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.access(1'b0, a, 8'h00, q);
    chk("read data", e, q);
  endtask : rdc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, q);
  endtask : wr
  // status and alert pins settle two edges after a reading or mask change
  task automatic pins(input logic [4:0] s, input logic e2, input logic e3);
    repeat (3) @(negedge clock_i);
    chk("status", {3'h0, s}, {3'h0, status_o});
    chk("alerts", {6'h00, e2, e3}, {6'h00, a2, a3});
  endtask : pins
  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (5) @(negedge clock_i);
    srst_i = 1'b0;
    rdc(8'h0D, 8'h00);
    rdc(8'h0E, 8'h07);
    rdc(8'h40, 8'h55);
    rdc(8'h33, 8'h00);
    wr(8'h0E, 8'hFF);
    rdc(8'h0E, 8'h1F);
    wr(8'h40, 8'hB0);
    rdc(8'h40, 8'h30);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      wr(8'h0D, 8'h1F ^ (8'h01 << i));
      wr(8'h0E, 8'h01 << i);
      t[i] = 8'h30;
      pins(5'h01 << i, 1'b0, 1'b1);
      wr(8'h0D, 8'h01 << i);
      wr(8'h0E, 8'h1F ^ (8'h01 << i));
      pins(5'h01 << i, 1'b1, 1'b0);
      t[i] = 8'h2C;
      pins(5'h01 << i, 1'b1, 1'b0);
      t[i] = 8'h2B;
      pins(5'h01 << i, 1'b1, 1'b0);
      t[i] = 8'h2A;
      pins(5'h00, 1'b1, 1'b1);
    end
    rdc(8'h0D, 8'h10);
    $display("test alerts done");
    close_out();
  end
  initial begin
    #1000000;
    failures++;
    close_out();
  end
endmodule : otam_alert_regs_tb
